// ===== design/cif_pkg.sv
// Purpose: constants for the codec interrupt flag block
// Assumes: 200 MHz core clock, one clock domain
// Notes: offsets are page 0 register numbers
//
// How it works
// - Sticky flag 45.D6 sets when ADC power falls below gain-loop noise level
// - Sticky flags are read-only, clear on read, set again on a new event
// - Flags 45.D4 and 45.D3 catch ADC engine standard and auxiliary ports
// - Bit D2 of 45 and 47 shows DC measurement data available
// - Live 46.D7 shows short circuit at headphone or speaker driver
// - Live 46.D5 shows headset button currently pressed
// - Live 46.D4 shows headset inserted, zero after removal
// - Live 46.D3 and D2 show left and right power above compressor level
// - Live 46.D1 and D0 show DAC engine standard and auxiliary ports
// - Live 47.D6 shows ADC power below gain-loop noise level
// - Live 47.D4 and D3 show ADC engine standard and auxiliary ports
// - Control D7 lets headset insertion events raise the interrupt
// - Control D6 lets button press events raise the interrupt
// - Control D5 lets compressor power events raise the interrupt
// - Control D4 lets gain-loop noise events raise the interrupt
// - Control D3 lets short-circuit events raise the interrupt
// - Control D2 lets processing engine events raise the interrupt
// - Control D1 lets DC measurement ready events raise the interrupt
// - Control D0 clear gives one 2 ms high pulse per interrupt
// - Control D0 set repeats 2 ms pulses each 4 ms until 44 and 45 read
// - Sticky 44 latches short, button, insertion and compressor events
// - Interrupt drives general pin one when its function code is 0101
package cif_pkg;
    // ***************************
    // Register offsets
    // ***************************
    localparam logic [7:0] CIF_OFF_DAC_STICKY = 8'h2C;
    localparam logic [7:0] CIF_OFF_ADC_STICKY = 8'h2D;
    localparam logic [7:0] CIF_OFF_DAC_LIVE = 8'h2E;
    localparam logic [7:0] CIF_OFF_ADC_LIVE = 8'h2F;
    localparam logic [7:0] CIF_OFF_CTRL = 8'h30;
    localparam logic [7:0] CIF_CTRL_RESET = 8'h00;
    localparam logic [7:0] CIF_RSV_RESET = 8'h00;
    // Writable reserved bits of 45 and 47
    localparam logic [7:0] CIF_RSV_MASK = 8'hA3;
    // ***************************
    // Control bit positions
    // ***************************
    localparam int CIF_EN_INSERT = 7;
    localparam int CIF_EN_BUTTON = 6;
    localparam int CIF_EN_DRC = 5;
    localparam int CIF_EN_AGC = 4;
    localparam int CIF_EN_SHORT = 3;
    localparam int CIF_EN_ENGINE = 2;
    localparam int CIF_EN_DC = 1;
    localparam int CIF_REPEAT = 0;
    // ***************************
    // Source vector positions
    // ***************************
    localparam int CIF_NSRC = 11;
    localparam int CIF_S_SHORT = 0;
    localparam int CIF_S_BUTTON = 1;
    localparam int CIF_S_INSERT = 2;
    localparam int CIF_S_LDRC = 3;
    localparam int CIF_S_RDRC = 4;
    localparam int CIF_S_AGC = 5;
    localparam int CIF_S_APE_STD = 6;
    localparam int CIF_S_APE_AUX = 7;
    localparam int CIF_S_DPE_STD = 8;
    localparam int CIF_S_DPE_AUX = 9;
    localparam int CIF_S_DC = 10;
    // ***************************
    // Timing
    // ***************************
    localparam int unsigned CIF_CLK_KHZ = 200000;
    localparam int unsigned CIF_PULSE_MS = 2;
    localparam int unsigned CIF_PERIOD_MS = 4;
    localparam int unsigned CIF_PULSE_CYC = CIF_PULSE_MS * CIF_CLK_KHZ;
    localparam int unsigned CIF_PERIOD_CYC = CIF_PERIOD_MS * CIF_CLK_KHZ;
    localparam int CIF_CNT_W = 20;
    localparam logic [3:0] CIF_PIN_FUNC_IRQ = 4'h5;
    typedef enum logic [2:0] {
        CIF_IDLE = 3'h1,
        CIF_HIGH = 3'h2,
        CIF_LOW = 3'h4
    } cif_state_t;
endpackage : cif_pkg

// ===== design/cif_pulse_gen.sv
// Purpose: pulse train for the first interrupt output
// Assumes: start and stop are one-cycle pulses on clk
// Notes: a start while busy is ignored
`timescale 1ns/1ps
module cif_pulse_gen #(
    parameter int unsigned PULSE_CYCLES = cif_pkg::CIF_PULSE_CYC,
    parameter int unsigned PERIOD_CYCLES = cif_pkg::CIF_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic stop,
    input wire logic repeat_mode,
    // Output
    output logic pulse_out
);
    import cif_pkg::*;

    localparam logic [CIF_CNT_W-1:0] HI_END = CIF_CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CIF_CNT_W-1:0] LO_END =
        CIF_CNT_W'(PERIOD_CYCLES - PULSE_CYCLES - 1);

    cif_state_t state;
    logic [CIF_CNT_W-1:0] cnt;

    // ***************************
    // Sequencer
    // ***************************
    // width, period, stop
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= CIF_IDLE;
            cnt <= '0;
            pulse_out <= 1'b0;
        end
        else
        begin
            case (state)
                CIF_IDLE:
                begin
                    cnt <= '0;
                    if (start)
                    begin
                        state <= CIF_HIGH;
                        pulse_out <= 1'b1;
                    end
                end
                CIF_HIGH:
                begin
                    if (stop)
                    begin
                        state <= CIF_IDLE;
                        pulse_out <= 1'b0;
                        cnt <= '0;
                    end
                    else if (cnt == HI_END)
                    begin
                        state <= repeat_mode ? CIF_LOW : CIF_IDLE;
                        pulse_out <= 1'b0;
                        cnt <= '0;
                    end
                    else
                    begin
                        cnt <= cnt + 1'b1;
                    end
                end
                CIF_LOW:
                begin
                    if (stop || !repeat_mode)
                    begin
                        state <= CIF_IDLE;
                        cnt <= '0;
                    end
                    else if (cnt == LO_END)
                    begin
                        state <= CIF_HIGH;
                        pulse_out <= 1'b1;
                        cnt <= '0;
                    end
                    else
                    begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default:
                begin
                    state <= CIF_IDLE;
                    pulse_out <= 1'b0;
                    cnt <= '0;
                end
            endcase
        end
    end

    // ***************************
    // Checks
    // ***************************
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_pulse_width: assert property (
        $fell(pulse_out) && !$past(stop) |-> $past(cnt) == HI_END)
        else $error("pulse width wrong");
    a_repeat_gap: assert property (
        $rose(pulse_out) && $past(state) == CIF_LOW |-> $past(cnt) == LO_END)
        else $error("repeat period wrong");
    a_single_stops: assert property (
        $fell(pulse_out) && !$past(repeat_mode) |-> state == CIF_IDLE)
        else $error("single pulse repeated");
    a_stop_ends: assert property (
        stop && state != CIF_IDLE |=> !pulse_out && state == CIF_IDLE)
        else $error("stop ignored");
    c_repeat_seen: cover property (
        $rose(pulse_out) && $past(state) == CIF_LOW);
endmodule : cif_pulse_gen

// ===== design/cif_flags.sv
// Purpose: interrupt flags, mask and first interrupt output
// Assumes: sources and register strobes come from core logic on clk
// Notes: read data appear one cycle after the read strobe
`timescale 1ns/1ps
module cif_flags #(
    parameter int unsigned PULSE_CYCLES = cif_pkg::CIF_PULSE_CYC,
    parameter int unsigned PERIOD_CYCLES = cif_pkg::CIF_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Event sources
    input wire logic short_circuit,
    input wire logic button_pressed,
    input wire logic headset_inserted,
    input wire logic left_drc_above,
    input wire logic right_drc_above,
    input wire logic agc_noise_low,
    input wire logic adc_engine_std,
    input wire logic adc_engine_aux,
    input wire logic dac_engine_std,
    input wire logic dac_engine_aux,
    input wire logic dc_meas_ready,
    // Pin routing
    input wire logic [3:0] pin_one_func,
    output logic first_irq_output,
    output logic general_pin_one_out,
    output logic general_pin_one_oe
);
    import cif_pkg::*;

    logic [CIF_NSRC-1:0] src;
    logic [CIF_NSRC-1:0] src_prev;
    logic [CIF_NSRC-1:0] rise;
    logic insert_change;
    logic [7:0] ctrl;
    logic [7:0] rsv_adc_sticky;
    logic [7:0] rsv_adc_live;
    logic [7:0] dac_sticky;
    logic [7:0] adc_sticky;
    logic [7:0] dac_live;
    logic [7:0] adc_live;
    logic rd_dac_sticky;
    logic rd_adc_sticky;
    logic seen_dac;
    logic seen_adc;
    logic trigger;
    logic stop;
    logic pulse;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // ***************************
    // Source edges
    // ***************************
    always_comb
    begin
        src = '0;
        src[CIF_S_SHORT] = short_circuit;
        src[CIF_S_BUTTON] = button_pressed;
        src[CIF_S_INSERT] = headset_inserted;
        src[CIF_S_LDRC] = left_drc_above;
        src[CIF_S_RDRC] = right_drc_above;
        src[CIF_S_AGC] = agc_noise_low;
        src[CIF_S_APE_STD] = adc_engine_std;
        src[CIF_S_APE_AUX] = adc_engine_aux;
        src[CIF_S_DPE_STD] = dac_engine_std;
        src[CIF_S_DPE_AUX] = dac_engine_aux;
        src[CIF_S_DC] = dc_meas_ready;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            src_prev <= '0;
        end
        else
        begin
            src_prev <= src;
        end
    end

    assign rise = src & ~src_prev;
    assign insert_change = src[CIF_S_INSERT] ^ src_prev[CIF_S_INSERT];

    // ***************************
    // Register decode
    // ***************************
    assign rd_dac_sticky = reg_rd && hit(reg_addr, CIF_OFF_DAC_STICKY);
    assign rd_adc_sticky = reg_rd && hit(reg_addr, CIF_OFF_ADC_STICKY);

    // ***************************
    // Control and reserved bits
    // ***************************
    // mask and mode storage
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl <= CIF_CTRL_RESET;
        end
        else if (reg_wr && hit(reg_addr, CIF_OFF_CTRL))
        begin
            ctrl <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsv_adc_sticky <= CIF_RSV_RESET;
            rsv_adc_live <= CIF_RSV_RESET;
        end
        else if (reg_wr)
        begin
            if (hit(reg_addr, CIF_OFF_ADC_STICKY))
            begin
                rsv_adc_sticky <= reg_wdata & CIF_RSV_MASK;
            end
            if (hit(reg_addr, CIF_OFF_ADC_LIVE))
            begin
                rsv_adc_live <= reg_wdata & CIF_RSV_MASK;
            end
        end
    end

    // ***************************
    // Sticky flags
    // ***************************
    // set wins over read clear
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dac_sticky <= 8'h00;
        end
        else
        begin
            if (rd_dac_sticky)
            begin
                dac_sticky <= 8'h00;
            end
            if (rise[CIF_S_SHORT])
            begin
                dac_sticky[7] <= 1'b1;
            end
            if (rise[CIF_S_BUTTON])
            begin
                dac_sticky[5] <= 1'b1;
            end
            if (insert_change)
            begin
                dac_sticky[4] <= 1'b1;
            end
            if (rise[CIF_S_LDRC])
            begin
                dac_sticky[3] <= 1'b1;
            end
            if (rise[CIF_S_RDRC])
            begin
                dac_sticky[2] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            adc_sticky <= 8'h00;
        end
        else
        begin
            if (rd_adc_sticky)
            begin
                adc_sticky <= 8'h00;
            end
            if (rise[CIF_S_AGC])
            begin
                adc_sticky[6] <= 1'b1;
            end
            if (rise[CIF_S_APE_STD])
            begin
                adc_sticky[4] <= 1'b1;
            end
            if (rise[CIF_S_APE_AUX])
            begin
                adc_sticky[3] <= 1'b1;
            end
        end
    end

    // ***************************
    // Live status
    // ***************************
    // DAC live
    assign dac_live = {short_circuit, 1'b0, button_pressed, headset_inserted,
                       left_drc_above, right_drc_above, dac_engine_std,
                       dac_engine_aux};
    assign adc_live = {1'b0, agc_noise_low, 1'b0, adc_engine_std,
                       adc_engine_aux, dc_meas_ready, 2'b00};

    // ***************************
    // Read data
    // ***************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                CIF_OFF_DAC_STICKY: reg_rdata <= dac_sticky;
                // live DC ready in sticky register
                CIF_OFF_ADC_STICKY:
                begin
                    reg_rdata <= adc_sticky | rsv_adc_sticky
                        | {5'h00, dc_meas_ready, 2'b00};
                end
                CIF_OFF_DAC_LIVE: reg_rdata <= dac_live;
                CIF_OFF_ADC_LIVE: reg_rdata <= adc_live | rsv_adc_live;
                CIF_OFF_CTRL: reg_rdata <= ctrl;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ***************************
    // Interrupt sources
    // ***************************
    // masked OR
    always_comb
    begin
        trigger = 1'b0;
        if (ctrl[CIF_EN_INSERT] && rise[CIF_S_INSERT])
        begin
            trigger = 1'b1;
        end
        if (ctrl[CIF_EN_BUTTON] && rise[CIF_S_BUTTON])
        begin
            trigger = 1'b1;
        end
        if (ctrl[CIF_EN_DRC] && (rise[CIF_S_LDRC] || rise[CIF_S_RDRC]))
        begin
            trigger = 1'b1;
        end
        if (ctrl[CIF_EN_AGC] && rise[CIF_S_AGC])
        begin
            trigger = 1'b1;
        end
        if (ctrl[CIF_EN_SHORT] && rise[CIF_S_SHORT])
        begin
            trigger = 1'b1;
        end
        if (ctrl[CIF_EN_ENGINE] && |rise[CIF_S_DPE_AUX:CIF_S_APE_STD])
        begin
            trigger = 1'b1;
        end
        if (ctrl[CIF_EN_DC] && rise[CIF_S_DC])
        begin
            trigger = 1'b1;
        end
    end

    // ***************************
    // Repeat stop tracking
    // ***************************
    // both sticky registers read
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            seen_dac <= 1'b0;
            seen_adc <= 1'b0;
        end
        else if (trigger || stop)
        begin
            seen_dac <= 1'b0;
            seen_adc <= 1'b0;
        end
        else
        begin
            seen_dac <= seen_dac | rd_dac_sticky;
            seen_adc <= seen_adc | rd_adc_sticky;
        end
    end

    assign stop = ctrl[CIF_REPEAT] && (seen_dac || rd_dac_sticky)
        && (seen_adc || rd_adc_sticky);

    cif_pulse_gen #(
        .PULSE_CYCLES(PULSE_CYCLES),
        .PERIOD_CYCLES(PERIOD_CYCLES)
    ) u_pulse (
        .clk(clk),
        .nrst(nrst),
        .start(trigger),
        .stop(stop),
        .repeat_mode(ctrl[CIF_REPEAT]),
        .pulse_out(pulse)
    );

    // ***************************
    // Outputs
    // ***************************
    // pin one routing
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            first_irq_output <= 1'b0;
            general_pin_one_out <= 1'b0;
            general_pin_one_oe <= 1'b0;
        end
        else
        begin
            first_irq_output <= pulse;
            general_pin_one_out <= (pin_one_func == CIF_PIN_FUNC_IRQ) && pulse;
            general_pin_one_oe <= (pin_one_func == CIF_PIN_FUNC_IRQ);
        end
    end

    // ***************************
    // Checks
    // ***************************
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_agc_sets: assert property (
        rise[CIF_S_AGC] |=> adc_sticky[6])
        else $error("agc flag not set");
    a_read_clears: assert property (
        rd_adc_sticky && !rise[CIF_S_AGC] |=> !adc_sticky[6])
        else $error("sticky not cleared");
    a_short_live: assert property (
        reg_rd && reg_addr == CIF_OFF_DAC_LIVE
        |=> reg_rdata[7] == $past(short_circuit))
        else $error("short live wrong");
    a_mask_off: assert property (
        ctrl == 8'h00 |-> !trigger)
        else $error("masked source fired");
    a_short_irq: assert property (
        ctrl[CIF_EN_SHORT] && rise[CIF_S_SHORT] && u_pulse.state == CIF_IDLE
        |=> ##1 first_irq_output)
        else $error("short gave no pulse");
    a_pin_route: assert property (
        pin_one_func == CIF_PIN_FUNC_IRQ |=> general_pin_one_out == $past(pulse))
        else $error("pin routing wrong");
    a_dac_set_wins: assert property (
        rd_dac_sticky && rise[CIF_S_SHORT] |=> dac_sticky[7])
        else $error("event lost on read");
    c_single: cover property ($rose(first_irq_output) && !ctrl[CIF_REPEAT]);
    c_repeat_stop: cover property (stop && pulse);
    c_insert: cover property (insert_change && ctrl[CIF_EN_INSERT]);
endmodule : cif_flags

// ===== dv/cif_host_model.sv
// Purpose: host side that watches the first interrupt line
// Assumes: reads use the block's one-cycle read strobe
// Notes: counts pulses and keeps the width of the last one
`timescale 1ns/1ps
module cif_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Interrupt line and answer mode
    input wire logic irq,
    input wire logic ack,
    // Read requests
    output logic [7:0] h_addr,
    output logic h_rd,
    // Observations
    output logic [7:0] pulses,
    output logic [7:0] width
);
    import cif_pkg::*;
    logic irq_d;
    logic [1:0] step;
    logic [7:0] run;
    // ***************************
    // Pulse observer
    // ***************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_d <= 1'b0;
            pulses <= 8'h00;
            run <= 8'h00;
            width <= 8'h00;
        end
        else
        begin
            irq_d <= irq;
            if (irq && !irq_d)
                pulses <= pulses + 8'h01;
            run <= irq ? run + 8'h01 : 8'h00;
            if (!irq && irq_d)
                width <= run;
        end
    end
    // ***************************
    // Acknowledge reads
    // ***************************
    // Read both sticky registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            step <= 2'h0;
            h_rd <= 1'b0;
            h_addr <= 8'h00;
        end
        else if (step == 2'h0 && ack && irq && !irq_d)
        begin
            step <= 2'h1;
            h_rd <= 1'b1;
            h_addr <= CIF_OFF_DAC_STICKY;
        end
        else if (step == 2'h1)
        begin
            step <= 2'h2;
            h_addr <= CIF_OFF_ADC_STICKY;
        end
        else
        begin
            // Idle address keeps moving
            step <= 2'h0;
            h_rd <= 1'b0;
            h_addr <= ~h_addr;
        end
    end
endmodule : cif_host_model

// ===== dv/test_cif_flags.sv
// Purpose: self-checking bench for the interrupt flag block
// Assumes: shortened pulse counts, host model on the line
// Notes: read results are checked from a queue of notes
`timescale 1ns/1ps
module test_cif_flags;
    import cif_pkg::*;
    localparam int unsigned PW = 8;
    localparam int unsigned PP = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] tb_addr = 8'h00;
    logic tb_rd = 1'b0;
    logic tb_wr = 1'b0;
    logic [7:0] tb_wdata = 8'h00;
    logic [10:0] src = '0;
    logic [3:0] pin_func = 4'h5;
    logic [3:0] pf_d = 4'h5;
    logic nrst_d = 1'b0;
    logic ack = 1'b0;
    logic pend = 1'b0;
    logic [7:0] sdac = 8'h00;
    logic [7:0] sadc = 8'h00;
    logic [7:0] exp_q[$];
    logic [7:0] rdata, h_addr, pulses, width, n;
    logic irq, pin_out, pin_oe, h_rd;
    int pin_bad = 0;
    int n_fail = 0;
    int comparisons = 0;
    cif_flags #(.PULSE_CYCLES(PW), .PERIOD_CYCLES(PP)) u_dut (
        .clk(clk), .nrst(nrst), .reg_addr(h_rd ? h_addr : tb_addr),
        .reg_wr(tb_wr), .reg_rd(tb_rd | h_rd), .reg_wdata(tb_wdata), .reg_rdata(rdata),
        .short_circuit(src[CIF_S_SHORT]), .button_pressed(src[CIF_S_BUTTON]),
        .headset_inserted(src[CIF_S_INSERT]), .left_drc_above(src[CIF_S_LDRC]),
        .right_drc_above(src[CIF_S_RDRC]), .agc_noise_low(src[CIF_S_AGC]),
        .adc_engine_std(src[CIF_S_APE_STD]), .adc_engine_aux(src[CIF_S_APE_AUX]),
        .dac_engine_std(src[CIF_S_DPE_STD]), .dac_engine_aux(src[CIF_S_DPE_AUX]),
        .dc_meas_ready(src[CIF_S_DC]), .pin_one_func(pin_func), .first_irq_output(irq),
        .general_pin_one_out(pin_out), .general_pin_one_oe(pin_oe));
    cif_host_model u_host (.clk(clk), .nrst(nrst), .irq(irq), .ack(ack), .h_addr(h_addr),
        .h_rd(h_rd), .pulses(pulses), .width(width));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // ***************************
    // Tasks
    // ***************************
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        comparisons++;
        if (got !== e)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tb_addr = a;
        tb_wdata = d;
        tb_wr = 1'b1;
        tick(1);
        tb_wr = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        tb_addr = a;
        tb_rd = 1'b1;
        exp_q.push_back(e);
        tick(1);
        tb_rd = 1'b0;
        tick(1);
    endtask : rd
    task automatic rd_sticky();
        rd(CIF_OFF_DAC_STICKY, sdac);
        sdac = 8'h00;
        rd(CIF_OFF_ADC_STICKY, sadc | {5'h00, src[CIF_S_DC], 2'h0});
        sadc = 8'h00;
    endtask : rd_sticky
    task automatic src_set(input logic [10:0] v);
        logic [10:0] r;
        logic [10:0] c;
        r = v & ~src;
        c = v ^ src;
        sdac |= {r[CIF_S_SHORT], 1'b0, r[CIF_S_BUTTON], c[CIF_S_INSERT],
            r[CIF_S_LDRC], r[CIF_S_RDRC], 2'h0};
        sadc |= {1'b0, r[CIF_S_AGC], 1'b0, r[CIF_S_APE_STD], r[CIF_S_APE_AUX], 3'h0};
        src = v;
        tick(2);
    endtask : src_set
    function automatic int en_src(input int b);
        case (b)
            7: return CIF_S_INSERT;
            6: return CIF_S_BUTTON;
            5: return CIF_S_LDRC + int'($urandom % 2);
            4: return CIF_S_AGC;
            3: return CIF_S_SHORT;
            2: return CIF_S_APE_STD + int'($urandom % 4);
            default: return CIF_S_DC;
        endcase
    endfunction : en_src
    task automatic summarize();
        if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // ***************************
    // Watchers
    // ***************************
    always @(posedge clk)
    begin
        if (pend)
            chk(rdata, exp_q.pop_front());
        pend = tb_rd;
        if (h_rd)
        begin
            if (h_addr == CIF_OFF_DAC_STICKY)
                sdac = 8'h00;
            else
                sadc = 8'h00;
        end
        // Pin follows the interrupt only for its code
        if (nrst_d && (pin_out !== (pf_d == CIF_PIN_FUNC_IRQ && irq)
            || pin_oe !== (pf_d == CIF_PIN_FUNC_IRQ)))
            pin_bad++;
        pf_d <= pin_func;
        nrst_d <= nrst;
    end
    initial
    begin
        tick(5000);
        n_fail++;
        summarize();
    end
    // ***************************
    // Main sequence
    // ***************************
    initial
    begin
        void'($urandom(58));
        tick(2);
        nrst = 1'b1;
        tick(1);
        rd(CIF_OFF_CTRL, CIF_CTRL_RESET);
        rd(CIF_OFF_DAC_LIVE, 8'h00);
        rd(CIF_OFF_ADC_LIVE, 8'h00);
        rd(8'h31, 8'h00);
        rd_sticky();
        n = 8'($urandom);
        wr(CIF_OFF_CTRL, n);
        rd(CIF_OFF_CTRL, n);
        wr(CIF_OFF_CTRL, 8'h00);
        // Read-only bits ignore writes; reserved bits only ever get zeros
        for (int a = 8'h2C; a <= 8'h2F; a++)
        begin
            wr(8'(a), ~CIF_RSV_MASK);
            rd(8'(a), 8'h00);
            wr(8'(a), 8'h00);
        end
        repeat (6)
        begin
            src_set(11'($urandom));
            rd(CIF_OFF_DAC_LIVE, {src[CIF_S_SHORT], 1'b0, src[CIF_S_BUTTON], src[CIF_S_INSERT],
                src[CIF_S_LDRC], src[CIF_S_RDRC], src[CIF_S_DPE_STD], src[CIF_S_DPE_AUX]});
            rd(CIF_OFF_ADC_LIVE, {1'b0, src[CIF_S_AGC], 1'b0, src[CIF_S_APE_STD],
                src[CIF_S_APE_AUX], src[CIF_S_DC], 2'h0});
            rd_sticky();
        end
        src_set('0);
        rd_sticky();
        // Each enable gates only its own source
        for (int b = 7; b >= 1; b--)
        begin
            int i;
            i = en_src(b);
            pin_func = ($urandom % 2) ? 4'h5 : 4'h3;
            n = pulses;
            wr(CIF_OFF_CTRL, 8'(1 << b));
            src_set(11'h1 << i);
            tick(PW + 4);
            chk(pulses, n + 8'h01);
            chk(width, 8'(PW));
            src_set('0);
            wr(CIF_OFF_CTRL, ~8'(1 << b) & 8'hFE);
            src_set(11'h1 << i);
            tick(PW + 4);
            chk(pulses, n + 8'h01);
            src_set('0);
            rd_sticky();
        end
        // Repeats until both sticky registers are read
        n = pulses;
        wr(CIF_OFF_CTRL, 8'h09);
        src_set(11'h1 << CIF_S_SHORT);
        tick(53);
        chk(pulses, n + 8'h03);
        rd(CIF_OFF_DAC_STICKY, sdac);
        sdac = 8'h00;
        tick(10);
        chk(pulses, n + 8'h04);
        rd(CIF_OFF_ADC_STICKY, sadc);
        sadc = 8'h00;
        tick(50);
        chk(pulses, n + 8'h04);
        src_set('0);
        ack = 1'b1;
        n = pulses;
        src_set(11'h1 << CIF_S_SHORT);
        tick(60);
        chk(pulses, n + 8'h01);
        chk(8'(width < PW), 8'h01);
        rd_sticky();
        ack = 1'b0;
        src_set('0);
        chk(8'(pin_bad), 8'h00);
        tick(2);
        summarize();
    end
endmodule : test_cif_flags
